// ---- design/multifunction_pin_router.sv ----
// Multifunction pin router with APB register access
//
// The APB register port was decided locally.
`timescale 1ns/10ps
`include "pin_router_map.svh"
module multifunction_pin_router
	import pin_router_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic global_reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic eeprom_load_valid,
	input wire logic [31:0] eeprom_load_data,
	input wire logic clock_run_src,
	input wire logic serialized_irq_src,
	input wire logic [15:0] irq_src,
	input wire logic [3:0] intx_src,
	input wire logic pc_pci_grant,
	input wire logic pc_pci_request,
	input wire logic smartcard_debug_tx,
	input wire logic card_audio_pwm,
	input wire logic flash_media_activity_led,
	input wire logic firewire_link_led,
	input wire logic socket_activity_led_1,
	input wire logic socket_activity_led_2,
	input wire logic combined_socket_led,
	input wire logic general_event_out,
	input wire logic ring_indicate_out,
	input wire logic diagnostic_observe_out,
	input wire logic [6:0] multi_pin_in,
	output logic [6:0] multi_pin_out,
	output logic [6:0] multi_pin_oe,
	output logic smartcard_debug_rx
);
	// Function classes that a decoded code resolves to
	localparam logic [2:0] K_RSVD = 3'h0;
	localparam logic [2:0] K_GPI = 3'h1;
	localparam logic [2:0] K_OUT = 3'h2;
	localparam logic [2:0] K_RX = 3'h3;

	logic [31:0] routing_q;
	logic [31:0] routing_d;
	gp_t gp_out_q;
	gp_t gp_status_q;
	gp_t gp_in_q;
	gp_t gp_meta_q;
	gp_t gp_prev_q;
	logic [6:0] pin_meta_q;
	logic [6:0] pin_sync_q;
	logic rx_q;
	load_state_t load_q;

	// Resolve pin, code to class and the driven level
	function automatic logic [3:0] route(input int unsigned pin, input sel_t c);
		logic [2:0] k;
		logic v;
		k = K_OUT;
		v = 1'b0;
		case (pin)
			6, 3: begin
				if (c == 4'h0) k = K_RSVD;
				else if (c == 4'h1) v = (pin == 6) ? clock_run_src : serialized_irq_src;
				else v = irq_src[c];
			end
			5: case (c)
				4'h0: k = K_GPI;
				4'h1: v = gp_out_q[4];
				4'h2: v = pc_pci_grant;
				4'h3: v = irq_src[3];
				4'h4: k = K_RX;
				4'h5: v = irq_src[5];
				4'h8: v = card_audio_pwm;
				4'h9: v = irq_src[9];
				4'hA: v = flash_media_activity_led;
				4'hB: v = firewire_link_led;
				4'hC: v = socket_activity_led_1;
				4'hD: v = combined_socket_led;
				4'hE: v = general_event_out;
				4'hF: v = irq_src[15];
				default: k = K_RSVD;
			endcase
			4: case (c)
				4'h0: k = K_GPI;
				4'h1: v = gp_out_q[3];
				4'h3: v = irq_src[3];
				4'h4: v = irq_src[4];
				4'h5: v = smartcard_debug_tx;
				4'h8: v = card_audio_pwm;
				4'h9: v = irq_src[9];
				4'hA: v = intx_src[3];
				4'hB: v = flash_media_activity_led;
				4'hC: v = ring_indicate_out;
				4'hD: v = combined_socket_led;
				4'hE: v = general_event_out;
				4'hF: v = irq_src[15];
				default: k = K_RSVD;
			endcase
			2: case (c)
				4'h0: k = K_GPI;
				4'h1: v = gp_out_q[2];
				4'h2: v = pc_pci_request;
				4'h3: v = irq_src[3];
				4'h4: v = irq_src[4];
				4'h5: v = irq_src[5];
				4'h8: v = card_audio_pwm;
				4'h9: v = flash_media_activity_led;
				4'hA: v = irq_src[10];
				4'hB: v = intx_src[2];
				4'hC: v = ring_indicate_out;
				4'hD: v = diagnostic_observe_out;
				4'hE: v = general_event_out;
				4'hF: v = irq_src[7];
				default: k = K_RSVD;
			endcase
			default: case (c)
				4'h0: k = K_GPI;
				4'h1: v = gp_out_q[pin];
				4'h2: v = intx_src[pin];
				4'h3: v = irq_src[3];
				4'h4: v = irq_src[4];
				4'h5: v = irq_src[5];
				4'h8: v = card_audio_pwm;
				4'h9: v = irq_src[9];
				4'hA: v = irq_src[10];
				4'hB: v = irq_src[11];
				4'hC: v = socket_activity_led_1;
				4'hD: v = socket_activity_led_2;
				4'hE: v = general_event_out;
				4'hF: v = irq_src[15];
				default: k = K_RSVD;
			endcase
		endcase
		return {k, v};
	endfunction : route

	// Which pin feeds each general-purpose input bit
	function automatic int unsigned gp_pin(input int unsigned i);
		case (i)
			0: return 0;
			1: return 1;
			2: return 2;
			3: return 4;
			default: return 5;
		endcase
	endfunction : gp_pin

	logic [3:0] route_res [7];
	logic [6:0] pin_is_gpi;
	logic [6:0] pin_is_rx;
	gp_t gp_live;

	always_comb begin
		for (int p = 0; p < `PIN_COUNT; p++) begin
			route_res[p] = route(p, routing_q[p*4 +: 4]);
			pin_is_gpi[p] = route_res[p][3:1] == K_GPI;
			pin_is_rx[p] = route_res[p][3:1] == K_RX;
			multi_pin_oe[p] = route_res[p][3:1] == K_OUT;
			multi_pin_out[p] = multi_pin_oe[p] & route_res[p][0];
		end
		for (int i = 0; i < `GP_W; i++) begin
			gp_live[i] = pin_is_gpi[gp_pin(i)] & pin_sync_q[gp_pin(i)];
		end
	end

	wire acc = psel & penable;
	wire wr_route = acc & pwrite & (paddr == `ROUTING_OFFSET);
	wire wr_gpo = acc & pwrite & (paddr == `GP_OUTPUT_OFFSET);
	wire wr_stat = acc & pwrite & (paddr == `GP_STATUS_OFFSET);
	wire [31:0] strb_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
	wire [31:0] route_wmask = strb_mask & `ROUTING_WMASK;
	wire gp_t gp_change = (gp_in_q ^ gp_prev_q);

	assign routing_d = (routing_q & ~route_wmask) | (pwdata & route_wmask);
	assign pready = 1'b1;
	wire hit = (paddr == `ROUTING_OFFSET) | (paddr == `GP_OUTPUT_OFFSET)
		| (paddr == `GP_STATUS_OFFSET) | (paddr == `GP_INPUT_OFFSET);
	assign pslverr = acc & ~hit;
	assign smartcard_debug_rx = rx_q;

	// Routing held only by global reset; bus reset leaves it
	always_ff @(posedge pclk or negedge global_reset_n) begin
		if (!global_reset_n) begin
			routing_q <= `ROUTING_RESET;
			gp_out_q <= '0;
			gp_status_q <= '0;
			load_q <= LOAD_IDLE;
		end else begin
			case (load_q)
				LOAD_IDLE: begin
					if (eeprom_load_valid) begin
						routing_q <= eeprom_load_data & `ROUTING_WMASK;
						load_q <= LOAD_DONE;
					end else if (wr_route) begin
						routing_q <= routing_d;
						load_q <= LOAD_DONE;
					end
				end
				LOAD_DONE: if (wr_route) routing_q <= routing_d;
				default: load_q <= LOAD_IDLE;
			endcase
			if (wr_gpo && pstrb[0]) gp_out_q <= pwdata[4:0];
			// Set wins over write-one clear
			gp_status_q <= (gp_status_q & ~(wr_stat && pstrb[0] ? pwdata[4:0] : 5'h00))
				| gp_change;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta_q <= '0;
			pin_sync_q <= '0;
			gp_in_q <= '0;
			gp_prev_q <= '0;
			rx_q <= 1'b0;
			prdata <= '0;
		end else begin
			pin_meta_q <= multi_pin_in;
			pin_sync_q <= pin_meta_q;
			gp_in_q <= gp_live;
			gp_prev_q <= gp_in_q;
			rx_q <= pin_is_rx[5] & pin_sync_q[5];
			if (psel && !penable && !pwrite) begin
				case (paddr)
					`ROUTING_OFFSET: prdata <= routing_q & `ROUTING_WMASK;
					`GP_OUTPUT_OFFSET: prdata <= {27'h0000000, gp_out_q};
					`GP_STATUS_OFFSET: prdata <= {27'h0000000, gp_status_q};
					`GP_INPUT_OFFSET: prdata <= {27'h0000000, gp_in_q};
					default: prdata <= '0;
				endcase
			end
		end
	end

	property p_top_zero;
		@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pwrite && paddr == `ROUTING_OFFSET |=> prdata[31:28] == 4'h0;
	endproperty
	a_top_zero: assert property (p_top_zero) else $error("top nibble not zero");
	property p_write_route;
		@(posedge pclk) disable iff (!global_reset_n)
		wr_route && pstrb == 4'hF |=> routing_q == (($past(pwdata)) & `ROUTING_WMASK);
	endproperty
	a_write_route: assert property (p_write_route) else $error("routing write lost");
	property p_rsvd_undriven;
		@(posedge pclk) disable iff (!presetn)
		routing_q[27:24] == 4'h0 |-> !multi_pin_oe[6];
	endproperty
	a_rsvd_undriven: assert property (p_rsvd_undriven) else $error("reserved pin driven");
	property p_gpo_drive;
		@(posedge pclk) disable iff (!presetn)
		routing_q[3:0] == 4'h1 |-> multi_pin_oe[0] && multi_pin_out[0] == gp_out_q[0];
	endproperty
	a_gpo_drive: assert property (p_gpo_drive) else $error("output not from register");
	property p_gpi_event;
		@(posedge pclk) disable iff (!global_reset_n || !presetn)
		gp_in_q[0] != gp_prev_q[0] |=> gp_status_q[0];
	endproperty
	a_gpi_event: assert property (p_gpi_event) else $error("input change missed");
	property p_pin3_serialized_irq;
		@(posedge pclk) disable iff (!presetn)
		routing_q[15:12] == 4'h1 |-> multi_pin_oe[3] && multi_pin_out[3] == serialized_irq_src;
	endproperty
	a_pin3_serialized_irq: assert property (p_pin3_serialized_irq) else $error("pin 3 route wrong");
	property p_pin5_rsvd;
		@(posedge pclk) disable iff (!presetn)
		routing_q[23:21] == 3'h3 |-> !multi_pin_oe[5];
	endproperty
	a_pin5_rsvd: assert property (p_pin5_rsvd) else $error("pin 5 reserved driven");
	property p_keep_route;
		@(posedge pclk) disable iff (!global_reset_n)
		!wr_route && !eeprom_load_valid |=> $stable(routing_q);
	endproperty
	a_keep_route: assert property (p_keep_route) else $error("routing changed");
	property p_eeprom_load;
		@(posedge pclk) disable iff (!global_reset_n)
		load_q == LOAD_IDLE && eeprom_load_valid
			|=> routing_q == ($past(eeprom_load_data) & `ROUTING_WMASK);
	endproperty
	a_eeprom_load: assert property (p_eeprom_load) else $error("preload lost");
endmodule : multifunction_pin_router

// ---- design/pin_router_map.svh ----
// Register offsets, field positions, reset values for the pin router
`ifndef PIN_ROUTER_MAP_SVH
`define PIN_ROUTER_MAP_SVH
// Register indices; each register owns one aligned word at four times its index
`define ROUTING_INDEX 10'h08C
`define GP_STATUS_INDEX 10'h088
`define GP_INPUT_INDEX 10'h08A
`define GP_OUTPUT_INDEX 10'h08B
`define ROUTING_OFFSET {`ROUTING_INDEX, 2'b00}
`define GP_STATUS_OFFSET {`GP_STATUS_INDEX, 2'b00}
`define GP_INPUT_OFFSET {`GP_INPUT_INDEX, 2'b00}
`define GP_OUTPUT_OFFSET {`GP_OUTPUT_INDEX, 2'b00}
`define ROUTING_RESET 32'h00001000
`define ROUTING_WMASK 32'h0FFFFFFF
`define FIELD_W 4
`define PIN_COUNT 7
`define GP_W 5
`endif

// ---- design/pin_router_pkg.sv ----
// Types for the multifunction pin router
package pin_router_pkg;
	typedef logic [3:0] sel_t;
	typedef logic [4:0] gp_t;
	typedef enum logic [1:0] {
		LOAD_IDLE = 2'b01,
		LOAD_DONE = 2'b10
	} load_state_t;
endpackage : pin_router_pkg

// ---- tb/board_side.sv ----
// Board-side model of the seven multifunction pins
`timescale 1ns/10ps
module board_side (
	input wire logic [6:0] multi_pin_out,
	input wire logic [6:0] multi_pin_oe,
	input wire logic [6:0] ext_level,
	output logic [6:0] multi_pin_in
);
	// Board level only where the device lets go, so a stale drive never leaks back
	assign multi_pin_in = (multi_pin_out & multi_pin_oe) | (ext_level & ~multi_pin_oe);
endmodule : board_side

// ---- tb/multifunction_pin_router_tb.sv ----
// Self-checking bench for the multifunction pin router
`timescale 1ns/10ps
`include "pin_router_map.svh"
module multifunction_pin_router_tb;
	import pin_router_pkg::*;
	logic pclk = 0, presetn = 0, global_reset_n_n = 0, psel = 0, penable = 0, pwrite = 0, eld = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, edata = 0, rd, prdata, seed = 84988;
	logic pready, pslverr, er, sc_rx;
	logic [33:0] src = 0;
	logic [6:0] ext = 0, pin_in, pin_out, pin_oe;
	int failures = 0, compares = 0, cyc = 0;
	// Per pin, byte per code: source index, 30 gp out, 31 undriven, 32 unknown
	logic [127:0] tbl [7] = '{
		128'h0F1D1B1A0B0A09173131050403103031,
		128'h0F1D1B1A323232323231323232113031,
		128'h071D1F1E120A18173131050403153031,
		128'h0F0E0D0C0B0A09080706050403022131,
		128'h0F1D1C1E181309173131160403313031,
		128'h0F1D1C1A191809173131053103143031,
		128'h0F0E0D0C0B0A09080706050403022031};
	multifunction_pin_router u_dut (.pclk, .presetn, .global_reset_n(global_reset_n_n), .psel, .penable,
		.pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr,
		.eeprom_load_valid(eld), .eeprom_load_data(edata), .clock_run_src(src[32]),
		.serialized_irq_src(src[33]), .irq_src(src[15:0]), .intx_src(src[19:16]),
		.pc_pci_grant(src[20]), .pc_pci_request(src[21]), .smartcard_debug_tx(src[22]),
		.card_audio_pwm(src[23]), .flash_media_activity_led(src[24]),
		.firewire_link_led(src[25]), .socket_activity_led_1(src[26]),
		.socket_activity_led_2(src[27]), .combined_socket_led(src[28]),
		.general_event_out(src[29]), .ring_indicate_out(src[30]),
		.diagnostic_observe_out(src[31]), .multi_pin_in(pin_in), .multi_pin_out(pin_out),
		.multi_pin_oe(pin_oe), .smartcard_debug_rx(sc_rx));
	board_side u_board (.multi_pin_out(pin_out), .multi_pin_oe(pin_oe), .ext_level(ext),
		.multi_pin_in(pin_in));
	always #5 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			wrap_up();
		end
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic chk(input bit ok, input string m);
		compares++;
		if (!ok) begin
			failures++;
			$display("Error at %0t: %s", $time, m);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask : apb
	task automatic pins(input logic [31:0] r, input logic [31:0] g);
		logic [7:0] e;
		for (int p = 0; p < 7; p++) begin
			e = tbl[p][r[p*4+:4]*8+:8];
			if (e == 8'h31) chk(pin_oe[p] === 1'b0, "pin driven");
			else if (e == 8'h30) chk(pin_oe[p] === 1'b1 && pin_out[p] === g[p < 3 ? p : p - 1], "gp out");
			else if (e != 8'h32) chk(pin_oe[p] === 1'b1 && pin_out[p] === src[e[5:0]], "routed");
		end
	endtask : pins
	task automatic route(input logic [31:0] r, input logic [31:0] g);
		logic [63:0] w;
		apb(1, `ROUTING_OFFSET, r);
		apb(1, `GP_OUTPUT_OFFSET, {27'h0, g[4:0]});
		w = {rnd(), rnd()};
		src <= w[33:0];
		ext <= w[40:34];
		apb(0, `ROUTING_OFFSET, 0);
		chk(rd === (r & `ROUTING_WMASK), "readback");
		chk(er === 1'b0, "mapped access error");
		pins(r, g);
	endtask : route
	task automatic wrap_up();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1;
		global_reset_n_n <= 1;
		@(posedge pclk);
		apb(0, `ROUTING_OFFSET, 0);
		chk(rd === `ROUTING_RESET, "reset value");
		pins(`ROUTING_RESET, 0);
		eld <= 1;
		edata <= 32'hF2345678;
		@(posedge pclk) eld <= 0;
		apb(0, `ROUTING_OFFSET, 0);
		chk(rd === 32'h02345678, "preload");
		presetn <= 0;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		apb(0, `ROUTING_OFFSET, 0);
		chk(rd === 32'h02345678, "function reset");
		global_reset_n_n <= 0;
		repeat (2) @(posedge pclk);
		global_reset_n_n <= 1;
		@(posedge pclk);
		apb(0, `ROUTING_OFFSET, 0);
		chk(rd === `ROUTING_RESET, "global reset");
		apb(1, 12'h100, 32'hFFFFFFFF);
		chk(er === 1'b1, "unmapped write");
		apb(0, `ROUTING_OFFSET, 0);
		chk(rd === `ROUTING_RESET, "unmapped write landed");
		$display("test resets done");
		for (int c = 0; c < 16; c++) route({4'h0, {7{c[3:0]}}}, rnd());
		for (int i = 0; i < 40; i++) route(rnd(), rnd());
		$display("test routing done");
		route(32'h0, 0);
		ext <= 0;
		repeat (8) @(posedge pclk);
		apb(1, `GP_STATUS_OFFSET, 32'h1F);
		apb(0, `GP_STATUS_OFFSET, 0);
		chk(rd[4:0] === 5'h00, "status clear");
		ext <= 7'h7F;
		repeat (8) @(posedge pclk);
		apb(0, `GP_STATUS_OFFSET, 0);
		chk(rd[4:0] === 5'h1F, "input event");
		apb(0, `GP_INPUT_OFFSET, 0);
		chk(rd[4:0] === 5'h1F, "input level");
		apb(1, `ROUTING_OFFSET, 32'h06666666);
		apb(1, `GP_STATUS_OFFSET, 32'h1F);
		ext <= 0;
		repeat (8) @(posedge pclk);
		apb(0, `GP_STATUS_OFFSET, 0);
		chk(rd[4:0] === 5'h00, "reserved input seen");
		for (int v = 0; v < 2; v++) begin
			apb(1, `ROUTING_OFFSET, 32'h00400000);
			ext <= v[0] ? 7'h20 : 7'h00;
			repeat (8) @(posedge pclk);
			chk(sc_rx === v[0], "debug rx");
		end
		eld <= 1;
		edata <= 32'h0FFFFFFF;
		@(posedge pclk) eld <= 0;
		apb(0, `ROUTING_OFFSET, 0);
		chk(rd === 32'h00400000, "late preload refused");
		$display("test gp input done");
		wrap_up();
	end
endmodule : multifunction_pin_router_tb
